// [hw/dcp_consts.svh]
/*
 * constants of the control access port: register offsets, field positions,
 * reset values and erase sequencing counts.
 * assumes inclusion by the testbench and the design file by bare name.
 */
// Operation
// - debugger write at 0x000 requests soft reset
// - erase trigger disables reset request until debug reset
// - erase flash, then sram, then user config
// - after erase, protection removed at next reset
// - protection status shows secure and non-secure settings
// - erase guard status shows user config setting
// - equal non-zero keys both sides start erase
// - debugger outgoing word with read-back status
// - cpu outgoing word read by debugger incoming register
// - outgoing write sets outgoing state word waiting
// - incoming read sets incoming state word consumed
// - cpu incoming word read-only, resets zero
// - lock bit 0 makes cpu key read-only
// - lock stays set until next reset
// - cpu key 32-bit read/write, resets zero
// - read-only identity register at top offset
// - erase progress busy while erase runs
// - sender write sets receiver incoming state waiting
// - receiver read returns sender outgoing state consumed
`ifndef DCP_CONSTS_SVH
`define DCP_CONSTS_SVH

`define DCP_DBG_RESET_REQ 12'h000
`define DCP_DBG_ERASE_TRIG 12'h004
`define DCP_DBG_ERASE_PROG 12'h008
`define DCP_DBG_PROT_STATE 12'h00C
`define DCP_DBG_GUARD_STATE 12'h018
`define DCP_DBG_GUARD_KEY 12'h01C
`define DCP_DBG_MB_OUT_WORD 12'h020
`define DCP_DBG_MB_OUT_STATE 12'h024
`define DCP_DBG_MB_IN_WORD 12'h028
`define DCP_DBG_MB_IN_STATE 12'h02C
`define DCP_DBG_IDENTITY 12'h0FC

`define DCP_CPU_MB_IN_WORD 12'h400
`define DCP_CPU_MB_IN_STATE 12'h404
`define DCP_CPU_MB_OUT_WORD 12'h480
`define DCP_CPU_MB_OUT_STATE 12'h484
`define DCP_CPU_KEY_LOCK 12'h500
`define DCP_CPU_GUARD_KEY 12'h504

`define DCP_RESET_REQ_BIT 0
`define DCP_ERASE_TRIG_BIT 0
`define DCP_BUSY_BIT 0
`define DCP_PROT_NS_BIT 0
`define DCP_PROT_S_BIT 1
`define DCP_GUARD_BIT 0
`define DCP_STATE_BIT 0
`define DCP_LOCK_BIT 0

`define DCP_WORD_ZERO 32'h0000_0000
// arbitrary neutral identity value
`define DCP_IDENTITY_VALUE 32'h0A5A_0001

// each erase phase waits for its engine done strobe, bounded by this timeout
`define DCP_PHASE_TIMEOUT_NS 40000
`define DCP_CLOCK_PERIOD_NS 10
`define DCP_PHASE_TIMEOUT_CYC (`DCP_PHASE_TIMEOUT_NS / `DCP_CLOCK_PERIOD_NS)

`endif

// [hw/dcp_pkg.sv]
/*
 * types of the control access port: erase sequencer states.
 * does not include the constants header.
 */
package dcp_pkg;
    typedef enum logic [2:0] {
        DCP_IDLE = 3'h0,
        DCP_FLASH = 3'h1,
        DCP_SRAM = 3'h3,
        DCP_UCFG = 3'h2,
        DCP_DONE = 3'h6
    } dcp_erase_e;
endpackage

// [hw/dcp_port.sv]
/*
 * control access port: debugger register view, cpu peripheral view,
 * mailboxes both ways, key compare and full erase sequencer.
 * assumes both register ports are synchronous to i_clock, a read or write
 * strobe lasts one cycle, and the erase engine answers with done strobes.
 */
`timescale 1ns/10ps
`include "dcp_consts.svh"

module dcp_port #(
    parameter int unsigned PHASE_TIMEOUT = `DCP_PHASE_TIMEOUT_CYC
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic [11:0] i_dbg_addr,
    input wire logic i_dbg_write,
    input wire logic i_dbg_read,
    input wire logic [31:0] i_dbg_wdata,
    output logic [31:0] o_dbg_rdata,
    input wire logic [11:0] i_cpu_addr,
    input wire logic i_cpu_write,
    input wire logic i_cpu_read,
    input wire logic [31:0] i_cpu_wdata,
    output logic [31:0] o_cpu_rdata,
    input wire logic i_port_protection_setting,
    input wire logic i_secure_port_protection_setting,
    input wire logic i_erase_guard,
    output logic o_soft_reset_req,
    output logic o_erase_flash,
    output logic o_erase_sram,
    output logic o_erase_ucfg,
    input wire logic i_erase_done,
    output logic o_protection_cleared,
    output dcp_pkg::dcp_erase_e o_erase_state
);
    import dcp_pkg::*;

    dcp_erase_e state;
    dcp_erase_e next_state;
    logic reset_disabled;
    logic [31:0] dbg_key;
    logic [31:0] cpu_key;
    logic key_locked;
    logic [31:0] d2c_word;
    logic d2c_waiting;
    logic [31:0] c2d_word;
    logic c2d_waiting;
    logic [31:0] phase_cnt;
    logic erase_start;
    logic phase_end;
    logic dbg_wr_trig;

    assign dbg_wr_trig = i_dbg_write && i_dbg_addr == `DCP_DBG_ERASE_TRIG
        && i_dbg_wdata[`DCP_ERASE_TRIG_BIT];
    // a guard enabled in the user config area blocks the plain trigger
    assign erase_start = state == DCP_IDLE && ((dbg_wr_trig && !i_erase_guard)
        || (dbg_key != `DCP_WORD_ZERO && dbg_key == cpu_key));
    assign phase_end = i_erase_done || phase_cnt == PHASE_TIMEOUT - 1;

    // soft reset request, one pulse per write
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_soft_reset_req <= 1'b0;
        end else begin
            o_soft_reset_req <= i_dbg_write && i_dbg_addr == `DCP_DBG_RESET_REQ
                && i_dbg_wdata[`DCP_RESET_REQ_BIT] && !reset_disabled;
        end
    end

    // reset request stays disabled from the erase trigger write (guarded or not) or key-match start until the debug reset
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            reset_disabled <= 1'b0;
        end else if (dbg_wr_trig || erase_start) begin
            reset_disabled <= 1'b1;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            DCP_IDLE: begin
                if (erase_start) begin
                    next_state = DCP_FLASH;
                end
            end
            DCP_FLASH: begin
                if (phase_end) begin
                    next_state = DCP_SRAM;
                end
            end
            DCP_SRAM: begin
                if (phase_end) begin
                    next_state = DCP_UCFG;
                end
            end
            DCP_UCFG: begin
                if (phase_end) begin
                    next_state = DCP_DONE;
                end
            end
            DCP_DONE: begin
                next_state = DCP_IDLE;
            end
            default: begin
                next_state = DCP_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state <= DCP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // timeout keeps a dead engine from hanging the port busy forever
    always_ff @(posedge i_clock) begin
        if (i_reset || state == DCP_IDLE || phase_end) begin
            phase_cnt <= 32'h0000_0000;
        end else begin
            phase_cnt <= phase_cnt + 32'h0000_0001;
        end
    end

    assign o_erase_flash = state == DCP_FLASH;
    assign o_erase_sram = state == DCP_SRAM;
    assign o_erase_ucfg = state == DCP_UCFG;
    assign o_erase_state = state;

    // factory defaults take effect at the next reset, flag is held until then
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_protection_cleared <= 1'b0;
        end else if (state == DCP_DONE) begin
            o_protection_cleared <= 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            dbg_key <= `DCP_WORD_ZERO;
        end else if (erase_start) begin
            dbg_key <= `DCP_WORD_ZERO;
        end else if (i_dbg_write && i_dbg_addr == `DCP_DBG_GUARD_KEY) begin
            dbg_key <= i_dbg_wdata;
        end
    end

    // keys clear once used so one match starts one erase
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            cpu_key <= `DCP_WORD_ZERO;
        end else if (erase_start) begin
            cpu_key <= `DCP_WORD_ZERO;
        end else if (i_cpu_write && i_cpu_addr == `DCP_CPU_GUARD_KEY && !key_locked) begin
            cpu_key <= i_cpu_wdata;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            key_locked <= 1'b0;
        end else if (i_cpu_write && i_cpu_addr == `DCP_CPU_KEY_LOCK
            && i_cpu_wdata[`DCP_LOCK_BIT]) begin
            key_locked <= 1'b1;
        end
    end

    // debugger to cpu mailbox; a write in the same cycle as a read wins
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            d2c_word <= `DCP_WORD_ZERO;
            d2c_waiting <= 1'b0;
        end else if (i_dbg_write && i_dbg_addr == `DCP_DBG_MB_OUT_WORD) begin
            d2c_word <= i_dbg_wdata;
            d2c_waiting <= 1'b1;
        end else if (i_cpu_read && i_cpu_addr == `DCP_CPU_MB_IN_WORD) begin
            d2c_waiting <= 1'b0;
        end
    end

    // cpu to debugger mailbox
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            c2d_word <= `DCP_WORD_ZERO;
            c2d_waiting <= 1'b0;
        end else if (i_cpu_write && i_cpu_addr == `DCP_CPU_MB_OUT_WORD) begin
            c2d_word <= i_cpu_wdata;
            c2d_waiting <= 1'b1;
        end else if (i_dbg_read && i_dbg_addr == `DCP_DBG_MB_IN_WORD) begin
            c2d_waiting <= 1'b0;
        end
    end

    // debugger read data, registered; unmapped offsets read zero
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_dbg_rdata <= `DCP_WORD_ZERO;
        end else if (i_dbg_read) begin
            o_dbg_rdata <= `DCP_WORD_ZERO;
            case (i_dbg_addr)
                `DCP_DBG_ERASE_PROG: o_dbg_rdata[`DCP_BUSY_BIT] <= state != DCP_IDLE;
                `DCP_DBG_PROT_STATE: begin
                    o_dbg_rdata[`DCP_PROT_NS_BIT] <= i_port_protection_setting;
                    o_dbg_rdata[`DCP_PROT_S_BIT] <= i_secure_port_protection_setting;
                end
                `DCP_DBG_GUARD_STATE: o_dbg_rdata[`DCP_GUARD_BIT] <= i_erase_guard;
                `DCP_DBG_GUARD_KEY: o_dbg_rdata <= dbg_key;
                `DCP_DBG_MB_OUT_WORD: o_dbg_rdata <= d2c_word;
                `DCP_DBG_MB_OUT_STATE: o_dbg_rdata[`DCP_STATE_BIT] <= d2c_waiting;
                `DCP_DBG_MB_IN_WORD: o_dbg_rdata <= c2d_word;
                `DCP_DBG_MB_IN_STATE: o_dbg_rdata[`DCP_STATE_BIT] <= c2d_waiting;
                `DCP_DBG_IDENTITY: o_dbg_rdata <= `DCP_IDENTITY_VALUE;
                default: o_dbg_rdata <= `DCP_WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_cpu_rdata <= `DCP_WORD_ZERO;
        end else if (i_cpu_read) begin
            o_cpu_rdata <= `DCP_WORD_ZERO;
            case (i_cpu_addr)
                `DCP_CPU_MB_IN_WORD: o_cpu_rdata <= d2c_word;
                `DCP_CPU_MB_IN_STATE: o_cpu_rdata[`DCP_STATE_BIT] <= d2c_waiting;
                `DCP_CPU_MB_OUT_WORD: o_cpu_rdata <= c2d_word;
                `DCP_CPU_MB_OUT_STATE: o_cpu_rdata[`DCP_STATE_BIT] <= c2d_waiting;
                `DCP_CPU_KEY_LOCK: o_cpu_rdata[`DCP_LOCK_BIT] <= key_locked;
                `DCP_CPU_GUARD_KEY: o_cpu_rdata <= cpu_key;
                default: o_cpu_rdata <= `DCP_WORD_ZERO;
            endcase
        end
    end

    reset_blocked_a: assert property (@(posedge i_clock) disable iff (i_reset)
        reset_disabled |=> !o_soft_reset_req)
        else $error("reset request issued after erase trigger");
    reset_pulse_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_dbg_write && i_dbg_addr == `DCP_DBG_RESET_REQ && i_dbg_wdata[0]
        && !reset_disabled) |=> o_soft_reset_req)
        else $error("reset request write not forwarded");
    erase_order_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (state == DCP_FLASH && phase_end) |=> state == DCP_SRAM ##0 o_erase_sram)
        else $error("sram phase does not follow flash");
    key_match_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (state == DCP_IDLE && dbg_key == cpu_key && dbg_key != 32'h0) |=> state == DCP_FLASH)
        else $error("matching keys did not start erase");
    key_lock_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (key_locked && !erase_start) |=> $stable(cpu_key))
        else $error("locked cpu key changed");
    lock_sticky_a: assert property (@(posedge i_clock) disable iff (i_reset)
        key_locked |=> key_locked)
        else $error("key lock released without reset");
    mbox_set_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_cpu_write && i_cpu_addr == `DCP_CPU_MB_OUT_WORD) |=> c2d_waiting ##1
        (!(i_dbg_read && i_dbg_addr == `DCP_DBG_MB_IN_WORD) [*1] or 1'b1))
        else $error("cpu mailbox write not marked waiting");
    mbox_clear_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_cpu_read && i_cpu_addr == `DCP_CPU_MB_IN_WORD
        && !(i_dbg_write && i_dbg_addr == `DCP_DBG_MB_OUT_WORD)) |=> !d2c_waiting)
        else $error("debugger outgoing state not consumed after cpu read");
    busy_read_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_dbg_read && i_dbg_addr == `DCP_DBG_ERASE_PROG && state != DCP_IDLE)
        |=> o_dbg_rdata == 32'h0000_0001)
        else $error("erase progress not busy during erase");
    ident_read_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_dbg_read && i_dbg_addr == `DCP_DBG_IDENTITY) |=> o_dbg_rdata == `DCP_IDENTITY_VALUE)
        else $error("identity register wrong");

    prot_state_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_dbg_read && i_dbg_addr == `DCP_DBG_PROT_STATE)
        |=> o_dbg_rdata == {30'h0, $past(i_secure_port_protection_setting),
        $past(i_port_protection_setting)})
        else $error("protection status does not follow the settings");

    guard_state_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_dbg_read && i_dbg_addr == `DCP_DBG_GUARD_STATE)
        |=> o_dbg_rdata == {31'h0, $past(i_erase_guard)})
        else $error("erase guard status does not follow the setting");

    out_waiting_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_dbg_write && i_dbg_addr == `DCP_DBG_MB_OUT_WORD) |=> d2c_waiting)
        else $error("debugger mailbox write not marked waiting");

    in_consumed_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_dbg_read && i_dbg_addr == `DCP_DBG_MB_IN_WORD
        && !(i_cpu_write && i_cpu_addr == `DCP_CPU_MB_OUT_WORD)) |=> !c2d_waiting)
        else $error("debugger incoming read did not consume the word");

    in_word_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_cpu_read && i_cpu_addr == `DCP_CPU_MB_IN_WORD)
        |=> o_cpu_rdata == $past(d2c_word))
        else $error("cpu incoming word read wrong");

    word_hold_a: assert property (@(posedge i_clock) disable iff (i_reset)
        !(i_dbg_write && i_dbg_addr == `DCP_DBG_MB_OUT_WORD) |=> $stable(d2c_word))
        else $error("cpu incoming word changed without a debugger write");

    key_write_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_cpu_write && i_cpu_addr == `DCP_CPU_GUARD_KEY && !key_locked && !erase_start)
        |=> cpu_key == $past(i_cpu_wdata))
        else $error("unlocked cpu key write lost");

    cpu_state_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_cpu_read && i_cpu_addr == `DCP_CPU_MB_IN_STATE)
        |=> o_cpu_rdata == {31'h0, $past(d2c_waiting)})
        else $error("cpu incoming state encoding wrong");

    dbg_state_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_dbg_read && i_dbg_addr == `DCP_DBG_MB_OUT_STATE)
        |=> o_dbg_rdata == {31'h0, $past(d2c_waiting)})
        else $error("debugger outgoing state encoding wrong");

    protect_clear_a: assert property (@(posedge i_clock) disable iff (i_reset)
        state == DCP_DONE |=> o_protection_cleared)
        else $error("protection not cleared after erase");

    clear_sticky_a: assert property (@(posedge i_clock) disable iff (i_reset)
        o_protection_cleared |=> o_protection_cleared)
        else $error("protection cleared flag dropped without reset");

    idle_read_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_dbg_read && i_dbg_addr == `DCP_DBG_ERASE_PROG && state == DCP_IDLE)
        |=> o_dbg_rdata == 32'h0000_0000)
        else $error("erase progress busy while idle");

    d2c_word_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_dbg_write && i_dbg_addr == `DCP_DBG_MB_OUT_WORD)
        |=> d2c_word == $past(i_dbg_wdata))
        else $error("debugger outgoing word not stored");

    c2d_word_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_dbg_read && i_dbg_addr == `DCP_DBG_MB_IN_WORD)
        |=> o_dbg_rdata == $past(c2d_word))
        else $error("debugger incoming word read wrong");

    phase_single_a: assert property (@(posedge i_clock) disable iff (i_reset)
        $onehot0({o_erase_flash, o_erase_sram, o_erase_ucfg}))
        else $error("more than one erase phase active");

    ucfg_order_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (state == DCP_SRAM && phase_end) |=> state == DCP_UCFG)
        else $error("user config phase does not follow sram");

    erase_begin_a: assert property (@(posedge i_clock) disable iff (i_reset)
        erase_start |=> o_erase_flash)
        else $error("erase did not open with flash");

    keys_clear_a: assert property (@(posedge i_clock) disable iff (i_reset)
        erase_start |=> dbg_key == 32'h0000_0000 && cpu_key == 32'h0000_0000)
        else $error("keys not cleared at erase start");

    reset_off_a: assert property (@(posedge i_clock) disable iff (i_reset)
        dbg_wr_trig |=> reset_disabled)
        else $error("erase trigger did not disable reset request");

    erase_run_c: cover property (@(posedge i_clock) state == DCP_UCFG ##1 state == DCP_DONE);
    mbox_trip_c: cover property (@(posedge i_clock) c2d_waiting ##1 !c2d_waiting);
    lock_set_c: cover property (@(posedge i_clock) !key_locked ##1 key_locked);
    key_erase_c: cover property (@(posedge i_clock) erase_start && !dbg_wr_trig);
    d2c_trip_c: cover property (@(posedge i_clock) d2c_waiting ##1 !d2c_waiting);
endmodule

// [verif/dcp_engine_model.sv]
/* erase engine model: ends each erase phase with a one-cycle done pulse.
   assumes the phase levels of the port, ORed; delay 15 means it never answers. */
`timescale 1ns/10ps
module dcp_engine_model (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_phase,
    input wire logic [3:0] i_delay,
    output logic o_done
);
    logic [3:0] count;
    // a stalled engine leaves the sequencer to move on by its own timeout
    always_ff @(posedge i_clock) begin
        if (i_reset || !i_phase || o_done) begin
            count <= 4'h0;
            o_done <= 1'h0;
        end else begin
            count <= count + 4'h1;
            o_done <= (count + 4'h1 == i_delay) && (i_delay != 4'hF);
        end
    end
endmodule

// [verif/tb_top.sv]
/* self-checking bench of the control access port: both register views,
   mailboxes, key lock, reset request and erase sequencing.
   assumes the erase engine model and the port's constants header. */
`timescale 1ns/10ps
`include "dcp_consts.svh"
module tb_top;
    import dcp_pkg::*;
    logic i_clock = 1'h0;
    logic i_reset = 1'h1;
    logic [11:0] dbg_addr = 12'h0, cpu_addr = 12'h0;
    logic dbg_wr = 1'h0, dbg_rd = 1'h0, cpu_wr = 1'h0, cpu_rd = 1'h0;
    logic [31:0] dbg_wdata = 32'h0, cpu_wdata = 32'h0, dbg_rdata, cpu_rdata, q;
    logic prot_ns = 1'h0, prot_s = 1'h0, guard = 1'h0, done;
    logic soft_rst, e_flash, e_sram, e_ucfg, prot_clr;
    logic [3:0] delay = 4'h6;
    dcp_erase_e e_state;
    int n_fail = 0, cmp_count = 0, cycles = 0;

    always #5 i_clock = ~i_clock;

    dcp_port #(.PHASE_TIMEOUT(8)) u_dut (.i_clock(i_clock), .i_reset(i_reset),
        .i_dbg_addr(dbg_addr), .i_dbg_write(dbg_wr), .i_dbg_read(dbg_rd),
        .i_dbg_wdata(dbg_wdata), .o_dbg_rdata(dbg_rdata), .i_cpu_addr(cpu_addr),
        .i_cpu_write(cpu_wr), .i_cpu_read(cpu_rd), .i_cpu_wdata(cpu_wdata),
        .o_cpu_rdata(cpu_rdata), .i_port_protection_setting(prot_ns),
        .i_secure_port_protection_setting(prot_s), .i_erase_guard(guard),
        .o_soft_reset_req(soft_rst), .o_erase_flash(e_flash), .o_erase_sram(e_sram),
        .o_erase_ucfg(e_ucfg), .i_erase_done(done), .o_protection_cleared(prot_clr),
        .o_erase_state(e_state));

    dcp_engine_model u_engine (.i_clock(i_clock), .i_reset(i_reset),
        .i_phase(e_flash | e_sram | e_ucfg), .i_delay(delay), .o_done(done));

    // the whole run needs well under a thousand cycles
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            $display("mismatch at %0t: run timed out", $time);
            results();
        end
    end

    task automatic results;
        $display("compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, w, got, exp);
        end
    endtask

    // one-cycle strobe; read data is taken just after the sampling edge
    task automatic acc(input bit cpu, input bit wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge i_clock);
        if (cpu) begin
            cpu_addr <= a;
            cpu_wdata <= d;
            cpu_wr <= wr;
            cpu_rd <= !wr;
        end else begin
            dbg_addr <= a;
            dbg_wdata <= d;
            dbg_wr <= wr;
            dbg_rd <= !wr;
        end
        @(posedge i_clock);
        {cpu_wr, cpu_rd, dbg_wr, dbg_rd} <= 4'h0;
        #1 q = cpu ? cpu_rdata : dbg_rdata;
    endtask

    task automatic rchk(input bit cpu, input logic [11:0] a, input logic [31:0] e,
                        input string w);
        acc(cpu, 1'h0, a, 32'h0);
        chk(q, e, w);
    endtask

    // one word through a mailbox; cpu selects the sending side
    task automatic mb(input bit cpu, input logic [31:0] d);
        logic [11:0] so, ro;
        so = cpu ? `DCP_CPU_MB_OUT_WORD : `DCP_DBG_MB_OUT_WORD;
        ro = cpu ? `DCP_DBG_MB_IN_WORD : `DCP_CPU_MB_IN_WORD;
        acc(cpu, 1'h1, so, d);
        rchk(cpu, so + 12'h4, 32'h1, "out state");
        rchk(!cpu, ro + 12'h4, 32'h1, "in state");
        rchk(!cpu, ro, d, "in word");
        rchk(!cpu, ro + 12'h4, 32'h0, "in state");
        rchk(cpu, so + 12'h4, 32'h0, "out state");
        acc(!cpu, 1'h1, ro, ~d);
        rchk(!cpu, ro, d, "in word read-only");
    endtask

    task automatic wait_st(input dcp_erase_e s, input logic [2:0] ph);
        for (int i = 0; i < 40 && e_state !== s; i++) begin
            @(posedge i_clock);
            #1;
        end
        chk(32'(e_state), 32'(s), "erase state");
        chk({29'h0, e_flash, e_sram, e_ucfg}, {29'h0, ph}, "phase lines");
    endtask

    task automatic poll;
        for (int i = 0; i < 50; i++) begin
            acc(1'h0, 1'h0, `DCP_DBG_ERASE_PROG, 32'h0);
            if (q === 32'h0)
                break;
        end
        chk(q, 32'h0, "progress idle");
    endtask

    task automatic rst;
        @(posedge i_clock);
        i_reset <= 1'h1;
        repeat (2) @(posedge i_clock);
        i_reset <= 1'h0;
    endtask

    initial begin
        repeat (2) @(posedge i_clock);
        i_reset <= 1'h0;
        rchk(1'h1, `DCP_CPU_MB_IN_WORD, 32'h0, "in word reset");
        rchk(1'h1, `DCP_CPU_KEY_LOCK, 32'h0, "lock reset");
        rchk(1'h1, `DCP_CPU_GUARD_KEY, 32'h0, "key reset");
        rchk(1'h0, `DCP_DBG_IDENTITY, `DCP_IDENTITY_VALUE, "identity");
        rchk(1'h0, 12'h010, 32'h0, "unmapped");
        for (int k = 0; k < 4; k++) begin
            {prot_s, prot_ns} <= 2'(k);
            guard <= k[0];
            rchk(1'h0, `DCP_DBG_PROT_STATE, 32'(k), "protection");
            rchk(1'h0, `DCP_DBG_GUARD_STATE, {31'h0, k[0]}, "guard");
        end
        mb(1'h0, 32'hA5C3_0F96);
        mb(1'h1, 32'h5A3C_F069);
        acc(1'h0, 1'h1, `DCP_DBG_RESET_REQ, 32'h1);
        chk({31'h0, soft_rst}, 32'h1, "reset pulse");
        @(posedge i_clock);
        #1 chk({31'h0, soft_rst}, 32'h0, "pulse end");
        acc(1'h1, 1'h1, `DCP_CPU_GUARD_KEY, 32'h1234_5678);
        rchk(1'h1, `DCP_CPU_GUARD_KEY, 32'h1234_5678, "key");
        acc(1'h1, 1'h1, `DCP_CPU_KEY_LOCK, 32'h1);
        acc(1'h1, 1'h1, `DCP_CPU_GUARD_KEY, 32'h0BAD_F00D);
        rchk(1'h1, `DCP_CPU_GUARD_KEY, 32'h1234_5678, "locked key");
        acc(1'h1, 1'h1, `DCP_CPU_KEY_LOCK, 32'h0);
        rchk(1'h1, `DCP_CPU_KEY_LOCK, 32'h1, "lock sticks");
        rst();
        rchk(1'h1, `DCP_CPU_KEY_LOCK, 32'h0, "lock cleared");
        // the guard refuses the trigger; the second try runs the full sequence
        guard <= 1'h1;
        acc(1'h0, 1'h1, `DCP_DBG_ERASE_TRIG, 32'h1);
        chk(32'(e_state), 32'(DCP_IDLE), "guarded trigger");
        guard <= 1'h0;
        acc(1'h0, 1'h1, `DCP_DBG_ERASE_TRIG, 32'h1);
        chk({31'h0, e_flash}, 32'h1, "flash first");
        rchk(1'h0, `DCP_DBG_ERASE_PROG, 32'h1, "busy");
        wait_st(DCP_SRAM, 3'h2);
        wait_st(DCP_UCFG, 3'h1);
        wait_st(DCP_DONE, 3'h0);
        poll();
        chk({31'h0, prot_clr}, 32'h1, "protection cleared");
        acc(1'h0, 1'h1, `DCP_DBG_RESET_REQ, 32'h1);
        chk({31'h0, soft_rst}, 32'h0, "request disabled");
        rst();
        acc(1'h0, 1'h1, `DCP_DBG_RESET_REQ, 32'h1);
        chk({31'h0, soft_rst}, 32'h1, "request back");
        // stalled engine: the phases advance on the sequencer's timeout
        delay <= 4'hF;
        acc(1'h0, 1'h1, `DCP_DBG_GUARD_KEY, 32'h0000_0C3A);
        acc(1'h1, 1'h1, `DCP_CPU_GUARD_KEY, 32'h0000_0C3B);
        rchk(1'h0, `DCP_DBG_ERASE_PROG, 32'h0, "keys differ");
        acc(1'h1, 1'h1, `DCP_CPU_GUARD_KEY, 32'h0000_0C3A);
        wait_st(DCP_FLASH, 3'h4);
        wait_st(DCP_SRAM, 3'h2);
        wait_st(DCP_UCFG, 3'h1);
        poll();
        results();
    end
endmodule
